// >>> adc_input_select.sv
// adc_input_select: input multiplexer selection of the converter,
// scan sequencing and shared pin modes behind an AXI4-Lite slave
// assumes: SAMPLE_DONE is a one-cycle pulse from the converter
// sequencer on REF_CLK, one per finished sample
module adc_input_select #(
  parameter int NUM_INPUTS = adc_sel_pkg::LARGE_INPUTS
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // AXI4-Lite write
  input wire logic [adc_sel_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [adc_sel_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // converter sequencer
  input wire logic SAMPLE_DONE,
  // channel 0 selection
  output logic [3:0] CH0_POS_INPUT,
  output logic CH0_POS_LOW_REF,
  output logic CH0_NEG_AN1,
  output logic CH0_RESERVED,
  // channel 1-3 selection, channel 1 in the low nibble
  output logic [11:0] CH123_POS_INPUT,
  output logic [11:0] CH123_NEG_INPUT,
  output logic CH123_NEG_REF,
  output logic CH123_RESERVED,
  output logic SAMPLE_B_PHASE,
  // shared pins
  output logic [8:0] PORT_READ_EN,
  output logic [8:0] MUX_GROUNDED
);
  if (NUM_INPUTS != adc_sel_pkg::LARGE_INPUTS &&
      NUM_INPUTS != adc_sel_pkg::SMALL_INPUTS) begin : g_bad
    $error("NUM_INPUTS must be 6 or 9");
  end

  localparam logic [4:0] MAX_CODE = 5'(NUM_INPUTS - 1);
  localparam logic [3:0] NUM_IN = 4'(NUM_INPUTS);
  localparam bit LARGE = NUM_INPUTS == adc_sel_pkg::LARGE_INPUTS;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] ch123;
    logic [15:0] ch0;
    logic [8:0] scan;
    logic [8:0] pin_analog_digital_cfg;
    adc_sel_pkg::phase_t phase;
    logic [3:0] scan_last;
    logic scan_run;
    logic aw_held;
    logic w_held;
    logic [adc_sel_pkg::ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] ch0_pos;
    logic ch0_low;
    logic ch0_neg;
    logic ch0_rsv;
    logic [11:0] c123_pos;
    logic [11:0] c123_neg;
    logic c123_ref;
    logic c123_rsv;
  } state_t;
  state_t st;
  state_t next_st;

  logic is_b;
  logic scanning;
  logic [7:0] sel0;
  logic [2:0] sel123;
  logic [3:0] pick;
  logic found;
  logic [3:0] last;
  logic neg_ref;
  logic rsv123;
  logic [11:0] pos_w;
  logic [11:0] neg_w;
  logic aw_take;
  logic w_take;
  logic [adc_sel_pkg::ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s,
      input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v & m;
  endfunction : merge16

  assign is_b = st.phase == adc_sel_pkg::PHASE_B;
  assign scanning = st.ctrl[adc_sel_pkg::CTRL_SCAN] && !is_b;
  assign sel0 = is_b ? st.ch0[adc_sel_pkg::CH0_POS_B +: 8] :
                       st.ch0[adc_sel_pkg::CH0_POS_A +: 8];
  assign sel123 = is_b ? st.ch123[adc_sel_pkg::CH123_POS_B +: 3] :
                         st.ch123[adc_sel_pkg::CH123_POS_A +: 3];
  // last converted scan position; none yet restarts at the lowest
  assign last = st.scan_run ? st.scan_last : adc_sel_pkg::SCAN_NONE;

  scan_finder u_scan (
    .mask(st.scan),
    .last(last),
    .pick(pick),
    .found(found)
  );

  always_comb begin
    neg_ref = 1'b1;
    rsv123 = st.ctrl[adc_sel_pkg::CTRL_TWELVE];
    case (sel123[2:1])
      adc_sel_pkg::NEG_VREF_0, adc_sel_pkg::NEG_VREF_1: begin
        neg_ref = 1'b1;
      end
      adc_sel_pkg::NEG_HIGH_AN: begin
        neg_ref = !LARGE;
        rsv123 = rsv123 || !LARGE;
      end
      default: begin
        rsv123 = 1'b1;
      end
    endcase
    if (st.ctrl[adc_sel_pkg::CTRL_TWELVE]) begin
      neg_ref = 1'b1;
    end
  end

  genvar k;
  for (k = 0; k < 3; k++) begin : g_ch
    assign pos_w[k*4 +: 4] = (sel123[0] ? adc_sel_pkg::AN_POS_HIGH :
                             adc_sel_pkg::AN_POS_LOW) + 4'(k);
    assign neg_w[k*4 +: 4] = neg_ref ? 4'h0 :
                             adc_sel_pkg::AN_NEG_BASE + 4'(k);
  end

  always_comb begin
    next_st = st;
    aw_take = AWVALID && st.awready;
    w_take = WVALID && st.wready;
    wa = st.aw_held ? st.awaddr : AWADDR;
    wd = st.w_held ? st.wdata : WDATA;
    ws = st.w_held ? st.wstrb : WSTRB;

    // selections, registered so every output leaves a flip-flop
    if (scanning) begin
      next_st.ch0_pos = pick;
      next_st.ch0_low = !found || pick >= NUM_IN;
      next_st.ch0_rsv = 1'b0;
    end else begin
      next_st.ch0_pos = sel0[3:0];
      next_st.ch0_low = sel0[4:0] > MAX_CODE;
      next_st.ch0_rsv = sel0[4:0] > MAX_CODE;
    end
    next_st.ch0_neg = sel0[adc_sel_pkg::CH0_NEG_A];
    next_st.c123_pos = pos_w;
    next_st.c123_neg = neg_w;
    next_st.c123_ref = neg_ref;
    next_st.c123_rsv = rsv123;

    // sample sequencing
    if (SAMPLE_DONE) begin
      if (scanning && found) begin
        next_st.scan_last = pick;
        next_st.scan_run = 1'b1;
      end
      next_st.phase = (st.ctrl[adc_sel_pkg::CTRL_ALT] && !is_b) ?
                      adc_sel_pkg::PHASE_B : adc_sel_pkg::PHASE_A;
    end
    if (!st.ctrl[adc_sel_pkg::CTRL_ALT]) begin
      next_st.phase = adc_sel_pkg::PHASE_A;
    end
    if (!st.ctrl[adc_sel_pkg::CTRL_SCAN]) begin
      next_st.scan_run = 1'b0;
    end

    // write channel: address and data taken in either order
    if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = AWADDR;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.wdata = WDATA;
      next_st.wstrb = WSTRB;
    end
    if ((st.aw_held || aw_take) && (st.w_held || w_take) &&
        !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = adc_sel_pkg::RESP_OKAY;
      case ({wa[adc_sel_pkg::ADDR_W-1:2], 2'b00})
        adc_sel_pkg::OFF_CTRL: begin
          next_st.ctrl = 4'(merge16({12'h000, st.ctrl}, wd, ws,
                                    adc_sel_pkg::MASK_CTRL));
          // a new mode restarts the scan from the lowest input
          next_st.scan_run = 1'b0;
        end
        adc_sel_pkg::OFF_CH123: begin
          next_st.ch123 = merge16(st.ch123, wd, ws,
                                  adc_sel_pkg::MASK_CH123);
        end
        adc_sel_pkg::OFF_CH0: begin
          next_st.ch0 = merge16(st.ch0, wd, ws, adc_sel_pkg::MASK_CH0);
        end
        adc_sel_pkg::OFF_SCAN: begin
          next_st.scan = 9'(merge16({7'h00, st.scan}, wd, ws,
                                    adc_sel_pkg::MASK_PIN));
          next_st.scan_run = 1'b0;
        end
        adc_sel_pkg::OFF_PIN_ANALOG_DIGITAL_CFG: begin
          next_st.pin_analog_digital_cfg = 9'(merge16({7'h00, st.pin_analog_digital_cfg}, wd, ws,
                                    adc_sel_pkg::MASK_PIN));
        end
        adc_sel_pkg::OFF_STAT: begin
          next_st.bresp = adc_sel_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = adc_sel_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    // read channel: data one cycle after the address is taken
    if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end
    if (ARVALID && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = adc_sel_pkg::RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      case ({ARADDR[adc_sel_pkg::ADDR_W-1:2], 2'b00})
        adc_sel_pkg::OFF_CTRL: next_st.rdata[3:0] = st.ctrl;
        adc_sel_pkg::OFF_CH123: next_st.rdata[15:0] = st.ch123;
        adc_sel_pkg::OFF_CH0: next_st.rdata[15:0] = st.ch0;
        adc_sel_pkg::OFF_SCAN: next_st.rdata[8:0] = st.scan;
        adc_sel_pkg::OFF_PIN_ANALOG_DIGITAL_CFG: next_st.rdata[8:0] = st.pin_analog_digital_cfg;
        adc_sel_pkg::OFF_STAT: begin
          next_st.rdata[adc_sel_pkg::STAT_PHASE] = is_b;
          next_st.rdata[adc_sel_pkg::STAT_RUN] = st.scan_run;
          next_st.rdata[adc_sel_pkg::STAT_RSV0] = st.ch0_rsv;
          next_st.rdata[adc_sel_pkg::STAT_RSV123] = st.c123_rsv;
          next_st.rdata[adc_sel_pkg::STAT_IDX +: 4] = st.scan_last;
        end
        default: next_st.rresp = adc_sel_pkg::RESP_SLVERR;
      endcase
    end
    next_st.arready = !next_st.rvalid;

    if (!RST_N) begin
      next_st = '0;
      next_st.ctrl = adc_sel_pkg::RST_CTRL[3:0];
      next_st.ch123 = adc_sel_pkg::RST_CH123;
      next_st.ch0 = adc_sel_pkg::RST_CH0;
      next_st.scan = adc_sel_pkg::RST_SCAN[8:0];
      next_st.pin_analog_digital_cfg = adc_sel_pkg::RST_PIN_ANALOG_DIGITAL_CFG[8:0];
      next_st.phase = adc_sel_pkg::PHASE_A;
    end
  end

  always_ff @(posedge REF_CLK) begin
    st <= next_st;
  end

  pin_mode #(
    .NUM_INPUTS(NUM_INPUTS)
  ) u_pins (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .cfg(st.pin_analog_digital_cfg),
    .conv_off(st.ctrl[adc_sel_pkg::CTRL_OFF]),
    .port_read_en(PORT_READ_EN),
    .mux_grounded(MUX_GROUNDED)
  );

  assign AWREADY = st.awready;
  assign WREADY = st.wready;
  assign BVALID = st.bvalid;
  assign BRESP = st.bresp;
  assign ARREADY = st.arready;
  assign RVALID = st.rvalid;
  assign RRESP = st.rresp;
  assign RDATA = st.rdata;
  assign CH0_POS_INPUT = st.ch0_pos;
  assign CH0_POS_LOW_REF = st.ch0_low;
  assign CH0_NEG_AN1 = st.ch0_neg;
  assign CH0_RESERVED = st.ch0_rsv;
  assign CH123_POS_INPUT = st.c123_pos;
  assign CH123_NEG_INPUT = st.c123_neg;
  assign CH123_NEG_REF = st.c123_ref;
  assign CH123_RESERVED = st.c123_rsv;
  assign SAMPLE_B_PHASE = st.phase;

  a_neg_sel_b: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    is_b |=> CH0_NEG_AN1 == $past(st.ch0[adc_sel_pkg::CH0_NEG_B]))
    else $error("ch0 negative B not taken from bit 15");
  a_neg_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !is_b |=> CH0_NEG_AN1 == $past(st.ch0[adc_sel_pkg::CH0_NEG_A]))
    else $error("ch0 negative A not taken from bit 7");
  a_pos_sel_b: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (is_b && st.ch0[12:8] <= MAX_CODE) |=>
      (CH0_POS_INPUT == $past(st.ch0[11:8]) && !CH0_POS_LOW_REF))
    else $error("ch0 positive B wrong");
  a_pos_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!is_b && !scanning && st.ch0[4:0] > MAX_CODE) |=>
      (CH0_RESERVED && CH0_POS_LOW_REF))
    else $error("ch0 positive A code beyond range not flagged");
  a_ch123_neg: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!st.ctrl[adc_sel_pkg::CTRL_TWELVE] && !is_b && LARGE &&
     st.ch123[2:1] == adc_sel_pkg::NEG_HIGH_AN) |=>
      (!CH123_NEG_REF && CH123_NEG_INPUT == 12'h876))
    else $error("ch1-3 negative inputs not 6, 7, 8");
  a_ch123_pos: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!is_b && st.ch123[0]) |=> CH123_POS_INPUT == 12'h543)
    else $error("ch1-3 positive inputs not 3, 4, 5");
  a_twelve_rsv: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    st.ctrl[adc_sel_pkg::CTRL_TWELVE] |=> CH123_RESERVED)
    else $error("twelve-bit mode ch1-3 code not reserved");
  a_alt_swap: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (SAMPLE_DONE && st.ctrl[adc_sel_pkg::CTRL_ALT]) |=>
      st.phase != $past(st.phase))
    else $error("alternate mode did not swap phase");
  a_scan_member: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (scanning && found) |-> st.scan[pick])
    else $error("scan picked an unselected input");
  a_scan_absent: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (scanning && found && pick >= NUM_IN) |=> CH0_POS_LOW_REF)
    else $error("absent scanned input not on low reference");
  a_scan_order: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (SAMPLE_DONE && scanning && found && st.scan_run) |=>
      (st.scan_last > $past(st.scan_last) ||
       (($past(st.scan) >> $past(st.scan_last)) >> 1) == 9'h000))
    else $error("scan did not ascend");
endmodule : adc_input_select

// >>> adc_sel_pkg.sv
// package: register map, field positions and reset values of the
// converter input selection block
// assumes: an AXI4-Lite master with 32-bit data and byte addresses
package adc_sel_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CH123 = 8'h04;
  localparam logic [7:0] OFF_CH0 = 8'h08;
  localparam logic [7:0] OFF_SCAN = 8'h0c;
  localparam logic [7:0] OFF_PIN_ANALOG_DIGITAL_CFG = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // writable bits; all others read as zero
  localparam logic [15:0] MASK_CTRL = 16'h000f;
  localparam logic [15:0] MASK_CH123 = 16'h0707;
  localparam logic [15:0] MASK_CH0 = 16'h9f9f;
  localparam logic [15:0] MASK_PIN = 16'h01ff;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_CH123 = 16'h0000;
  localparam logic [15:0] RST_CH0 = 16'h0000;
  localparam logic [15:0] RST_SCAN = 16'h0000;
  localparam logic [15:0] RST_PIN_ANALOG_DIGITAL_CFG = 16'h0000;
  // control register
  localparam int CTRL_TWELVE = 0;
  localparam int CTRL_ALT = 1;
  localparam int CTRL_SCAN = 2;
  localparam int CTRL_OFF = 3;
  // channel 0 select: sample B byte above sample A byte
  localparam int CH0_NEG_B = 15;
  localparam int CH0_POS_B = 8;
  localparam int CH0_NEG_A = 7;
  localparam int CH0_POS_A = 0;
  // channel 1-3 select
  localparam int CH123_NEG_B = 9;
  localparam int CH123_POS_B = 8;
  localparam int CH123_NEG_A = 1;
  localparam int CH123_POS_A = 0;
  // status register
  localparam int STAT_PHASE = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_RSV0 = 2;
  localparam int STAT_RSV123 = 3;
  localparam int STAT_IDX = 4;
  // selection codes and input numbers
  localparam logic [1:0] NEG_VREF_0 = 2'h0;
  localparam logic [1:0] NEG_VREF_1 = 2'h1;
  localparam logic [1:0] NEG_HIGH_AN = 2'h2;
  localparam logic [3:0] AN_NEG_BASE = 4'h6;
  localparam logic [3:0] AN_POS_HIGH = 4'h3;
  localparam logic [3:0] AN_POS_LOW = 4'h0;
  localparam logic [3:0] SCAN_NONE = 4'hf;
  localparam int LARGE_INPUTS = 9;
  localparam int SMALL_INPUTS = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {PHASE_A, PHASE_B} phase_t;
endpackage : adc_sel_pkg

// >>> scan_finder.sv
// scan_finder: picks the next selected input above the last one,
// wrapping to the lowest selected input
// assumes: purely combinational, driven from registers
module scan_finder (
  // selection
  input wire logic [8:0] mask,
  input wire logic [3:0] last,
  // result
  output logic [3:0] pick,
  output logic found
);
  logic [8:0] above;
  logic [3:0] hi_pick;
  logic [3:0] lo_pick;
  logic hi_any;

  genvar i;
  for (i = 0; i < 9; i++) begin : g_above
    assign above[i] = mask[i] && (4'(i) > last);
  end

  always_comb begin
    hi_pick = 4'h0;
    lo_pick = 4'h0;
    hi_any = 1'b0;
    // walking downward leaves the lowest hit in place
    for (int k = 8; k >= 0; k--) begin
      if (above[k]) begin
        hi_pick = 4'(k);
        hi_any = 1'b1;
      end
      if (mask[k]) begin
        lo_pick = 4'(k);
      end
    end
    pick = hi_any ? hi_pick : lo_pick;
    found = |mask;
  end
endmodule : scan_finder

// >>> pin_mode.sv
// pin_mode: analog or digital mode of the nine shared pins
// assumes: cfg and conv_off come from registers on the same clock
module pin_mode #(
  parameter int NUM_INPUTS = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic [8:0] cfg,
  input wire logic conv_off,
  // pin controls
  output logic [8:0] port_read_en,
  output logic [8:0] mux_grounded
);
  typedef struct packed {
    logic [8:0] read_en;
    logic [8:0] grounded;
  } pin_state_t;
  pin_state_t st;
  pin_state_t next_st;
  logic [8:0] digital;

  genvar i;
  for (i = 0; i < 9; i++) begin : g_pin
    if (i < NUM_INPUTS) begin : g_real
      assign digital[i] = conv_off || cfg[i];
    end else begin : g_none
      // bit stays writable but cannot reach a pin that is absent
      assign digital[i] = 1'b1;
    end
  end

  always_comb begin
    next_st.read_en = digital;
    next_st.grounded = digital;
    if (!rst_n) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign port_read_en = st.read_en;
  assign mux_grounded = st.grounded;

  a_off_digital: assert property (@(posedge clk) disable iff (!rst_n)
    conv_off |=> (&port_read_en && &mux_grounded))
    else $error("pins not digital while converter off");
  a_cfg_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_off |=> port_read_en[0] == $past(cfg[0]))
    else $error("pin mode does not follow its bit");
endmodule : pin_mode

// >>> sample_source.sv
// sample_source: converter sequencer model that ends one sample per request
// assumes: req is a one-cycle pulse on clk; delay sets the answer latency
module sample_source (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic req,
  input wire logic [3:0] delay,
  // answer
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  // a varying delay lets the bench see prompt and slow samples
  always @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if (req && !busy) begin
      busy <= 1'b1;
      cnt <= delay;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      done <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : sample_source

// >>> test_adc_input_channel_select.sv
// test_adc_input_channel_select: self-checking bench with a register model
// assumes: NUM_INPUTS 9 and the package register offsets
module test_adc_input_channel_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0, RST_N = 1'b0, req = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_DONE;
  logic CH0_POS_LOW_REF, CH0_NEG_AN1, CH0_RESERVED, CH123_NEG_REF;
  logic CH123_RESERVED, SAMPLE_B_PHASE;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [3:0] WSTRB = 4'hf, delay = 4'h0, CH0_POS_INPUT;
  logic [1:0] BRESP, RRESP, rs;
  logic [11:0] CH123_POS_INPUT, CH123_NEG_INPUT;
  logic [8:0] PORT_READ_EN, MUX_GROUNDED;
  // the smaller part shares every input and answers the bus identically, except for the two reserved bits of the status register
  logic [3:0] pos6;
  logic low6, rsv6, ref6, c123rsv6;
  logic [8:0] pins6;
  int err_count = 0, checks_done = 0, phase = 0, idx = 0;
  int r[5] = '{0, 0, 0, 0, 0};
  int msk[5] = '{'h000f, 'h0707, 'h9f9f, 'h01ff, 'h01ff};

  adc_input_select #(.NUM_INPUTS(9)) uut (.REF_CLK, .RST_N, .AWADDR,
    .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .SAMPLE_DONE, .CH0_POS_INPUT, .CH0_POS_LOW_REF, .CH0_NEG_AN1,
    .CH0_RESERVED, .CH123_POS_INPUT, .CH123_NEG_INPUT, .CH123_NEG_REF,
    .CH123_RESERVED, .SAMPLE_B_PHASE, .PORT_READ_EN, .MUX_GROUNDED);
  adc_input_select #(.NUM_INPUTS(6)) uut_small (.REF_CLK, .RST_N, .AWADDR,
    .AWVALID, .AWREADY(), .WDATA, .WSTRB, .WVALID, .WREADY(), .BRESP(),
    .BVALID(), .BREADY, .ARADDR, .ARVALID, .ARREADY(), .RDATA(), .RRESP(),
    .RVALID(), .RREADY, .SAMPLE_DONE, .CH0_POS_INPUT(pos6),
    .CH0_POS_LOW_REF(low6), .CH0_NEG_AN1(), .CH0_RESERVED(rsv6),
    .CH123_POS_INPUT(), .CH123_NEG_INPUT(), .CH123_NEG_REF(ref6),
    .CH123_RESERVED(c123rsv6), .SAMPLE_B_PHASE(), .PORT_READ_EN(pins6),
    .MUX_GROUNDED());
  sample_source seq (.clk(REF_CLK), .rst_n(RST_N), .req(req),
    .delay(delay), .done(SAMPLE_DONE));

  initial forever #5 REF_CLK = ~REF_CLK;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // ready is registered, so its level at the falling edge is what the
  // next rising edge samples
  task automatic wr(input logic [7:0] a, input int d);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!b && n < 100) begin
      @(negedge REF_CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      rs = BRESP;
      n++;
      @(posedge REF_CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) BREADY <= 1'b0;
    end
    chk(b, 1'b1, "write answer");
  endtask : wr

  task automatic rdt(input logic [7:0] a);
    int n;
    logic ar, v;
    n = 0;
    v = 1'b0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!v && n < 100) begin
      @(negedge REF_CLK);
      ar = ARVALID && ARREADY;
      v = RVALID;
      rd = RDATA;
      rs = RRESP;
      n++;
      @(posedge REF_CLK);
      if (ar) ARVALID <= 1'b0;
      if (v) RREADY <= 1'b0;
    end
    chk(v, 1'b1, "read answer");
  endtask : rdt

  function automatic int nxt(input int m, input int last);
    for (int i = 1; i <= 9; i++) begin
      if (m[(last + i) % 9]) return (last + i) % 9;
    end
    return 15;
  endfunction : nxt

  task automatic put(input logic [7:0] a, input int d);
    wr(a, d);
    r[a / 4] = d & msk[a / 4];
    if (a == adc_sel_pkg::OFF_CTRL || a == adc_sel_pkg::OFF_SCAN) begin
      idx = nxt(r[3], 8);
    end
  endtask : put

  task automatic pulse;
    int n;
    n = 0;
    @(posedge REF_CLK);
    req <= 1'b1;
    delay <= 4'($urandom_range(0, 5));
    @(posedge REF_CLK);
    req <= 1'b0;
    while (SAMPLE_DONE !== 1'b1 && n < 50) begin
      @(negedge REF_CLK);
      n++;
    end
    if (r[0][2] && phase == 0) idx = nxt(r[3], idx);
    if (r[0][1]) phase = 1 - phase;
  endtask : pulse

  task automatic outs;
    int c, p, code;
    logic sa;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    // sample B uses the upper fields of both select registers
    c = (r[1] >> (phase ? 9 : 1)) & 3;
    p = (r[1] >> (phase ? 8 : 0)) & 1;
    code = phase ? r[2][12:8] : r[2][4:0];
    sa = r[0][2] && phase == 0;
    chk(SAMPLE_B_PHASE, phase, "phase");
    if (sa || code < 9) begin
      chk(CH0_POS_INPUT, sa ? idx : code, "ch0 pos");
    end
    if (sa || code < 6) begin
      chk(pos6, sa ? idx : code, "ch0 pos small");
    end
    chk(CH0_POS_LOW_REF, sa ? idx > 8 : code > 8, "ch0 low");
    chk(low6, sa ? idx > 5 : code > 5, "ch0 low small");
    chk(CH0_RESERVED, !sa && code > 8, "ch0 rsv");
    chk(rsv6, !sa && code > 5, "ch0 rsv small");
    chk(CH0_NEG_AN1, phase ? r[2][15] : r[2][7], "ch0 neg");
    chk(PORT_READ_EN, r[0][3] ? 'h1ff : r[4], "read en");
    chk(MUX_GROUNDED, r[0][3] ? 'h1ff : r[4], "grounded");
    chk(pins6, r[0][3] ? 'h1ff : r[4] | 'h1c0, "pins small");
    chk(CH123_RESERVED, r[0][0] || c == 3, "ch123 rsv");
    chk(c123rsv6, r[0][0] || c >= 2, "ch123 rsv small");
    chk(ref6, 1, "ch123 ref small");
    if (!(r[0][0] || c == 3)) begin
      chk(CH123_POS_INPUT, p ? 'h543 : 'h210, "ch123 pos");
      chk(CH123_NEG_INPUT, c == 2 ? 'h876 : 0, "ch123 neg");
      chk(CH123_NEG_REF, c != 2, "ch123 ref");
    end
  endtask : outs

  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h282a3224));
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    for (int a = 0; a <= 'h10; a += 4) begin
      rdt(8'(a));
      chk(rd, 0, "reset value");
    end
    rdt(8'h18);
    chk({rs, rd[15:0]}, {adc_sel_pkg::RESP_SLVERR, 16'h0}, "unmapped rd");
    wr(8'h18, 'hffff);
    chk(rs, adc_sel_pkg::RESP_SLVERR, "unmapped wr");
    wr(adc_sel_pkg::OFF_STAT, 'hffff);
    chk(rs, adc_sel_pkg::RESP_OKAY, "status wr");
    for (int a = 0; a <= 'h10; a += 4) begin
      put(8'(a), $urandom);
      rdt(8'(a));
      chk(rd, r[a / 4], "readback");
    end
    $display("test registers done");
    put(adc_sel_pkg::OFF_CH0, 0);
    for (int c = 0; c < 16; c++) begin
      put(adc_sel_pkg::OFF_CTRL, c >> 3);
      put(adc_sel_pkg::OFF_CH123, (c & 7) | ($urandom & 'h0700));
      outs();
    end
    $display("test channels 1-3 done");
    for (int k = 0; k < 6; k++) begin
      put(adc_sel_pkg::OFF_PIN_ANALOG_DIGITAL_CFG, $urandom);
      put(adc_sel_pkg::OFF_CH0, $urandom_range(0, 9) |
          ($urandom_range(0, 9) << 8) | ($urandom & 'h8080));
      put(adc_sel_pkg::OFF_CTRL, 2 | ((k & 1) << 3));
      outs();
      pulse();
      outs();
      pulse();
      outs();
    end
    $display("test channel 0 and pins done");
    for (int k = 0; k < 3; k++) begin
      put(adc_sel_pkg::OFF_SCAN, k == 0 ? 'h101 : $urandom_range(1, 511));
      put(adc_sel_pkg::OFF_CTRL, 4);
      outs();
      repeat (6) begin
        pulse();
        outs();
      end
    end
    $display("test scan done");
    complete_run();
  end
endmodule : test_adc_input_channel_select
